// >>> include/msrb_pkg.sv
// Constants, field layouts and carrier types of the motion sensor register bank.
// Assumes one 40 MHz clock and a serial port sampled on that clock.
//
// Behaviour
// (R01) Every register is reached through the four-wire serial port.
// (R02) Address byte: top bit one writes, zero reads; seven address bits; one data byte.
// (R03) Address zero returns a fixed read-only 8-bit part identity.
// (R04) The part identity never changes under reset, writes or activity.
// (R05) Address one returns a read-only 8-bit silicon revision.
// (R06) Motion status bit 7 shows motion since last read; other bits read zero.
// (R07) Any write to motion status clears flag and both displacements; data not kept.
// (R08) Host reads motion status first, then displacements when flagged.
// (R09) X displacement accumulates counts since last report; reading clears it.
// (R10) Y displacement accumulates counts since last report; reading clears it.
// (R11) Displacements are 8-bit two's complement, saturating at -128 and +127.
// (R12) Host reads X then Y displacement back to back.
// (R13) Surface quality is upper 8 bits of a 9-bit feature count, capped at 144.
// (R14) Surface quality falls to zero with no surface; may vary per frame.
// (R15) Exposure count is 16-bit; high byte at six, low byte at seven.
// (R16) Exposure adjusts itself to keep peak pixel within its operating range.
// (R17) Host reads exposure high byte then low byte consecutively.
// (R18) Writes to read-only registers do nothing; reserved bits read zero.
// (R19) Measurement values stay stable during a read; update at frame boundaries.
package msrb_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_PART_IDENTITY    = 7'h00;
	localparam logic [6:0] ADDR_SILICON_REVISION = 7'h01;
	localparam logic [6:0] ADDR_MOTION_STATUS    = 7'h02;
	localparam logic [6:0] ADDR_X_DISPLACEMENT   = 7'h03;
	localparam logic [6:0] ADDR_Y_DISPLACEMENT   = 7'h04;
	localparam logic [6:0] ADDR_SURFACE_QUALITY  = 7'h05;
	localparam logic [6:0] ADDR_EXPOSURE_HIGH    = 7'h06;
	localparam logic [6:0] ADDR_EXPOSURE_LOW     = 7'h07;
	localparam logic [6:0] ADDR_PEAK_PIXEL       = 7'h08;
	localparam logic [6:0] ADDR_PIXEL_TOTAL      = 7'h09;

	// ------------------------------------------------------------
	// Fields and values
	// ------------------------------------------------------------
	localparam int         DIR_BIT          = 7;
	localparam int         MOTION_FLAG_BIT  = 7;
	localparam int         PIX_SUM_HI       = 14;
	localparam int         PIX_SUM_LO       = 7;
	localparam logic [7:0] SURFACE_MAX      = 8'h90;
	localparam logic [7:0] RESET_BYTE       = 8'h00;
	localparam logic [15:0] EXPOSURE_RESET  = 16'h0000;
	localparam logic [15:0] EXPOSURE_MIN    = 16'h0001;
	localparam logic [15:0] EXPOSURE_MAX    = 16'hFFFF;
	localparam logic [15:0] EXPOSURE_STEP   = 16'h0001;
	localparam logic [6:0] PEAK_HIGH_LIMIT  = 7'h70;
	localparam logic [6:0] PEAK_LOW_LIMIT   = 7'h40;
	localparam logic [2:0] LAST_BIT         = 3'h7;
	localparam logic [7:0] DISP_POS_MAX     = 8'h7F;
	localparam logic [7:0] DISP_NEG_MAX     = 8'h80;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef enum logic {MSRB_ADDR, MSRB_DATA} msrb_phase_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic ncs;
	} msrb_pins_t;

	localparam msrb_pins_t PINS_RESET = '{sclk: 1'b1, mosi: 1'b0, ncs: 1'b1};

	typedef struct packed {
		logic [7:0]  dx;
		logic [7:0]  dy;
		logic [8:0]  features;
		logic [6:0]  peak;
		logic [14:0] pix_sum;
	} msrb_frame_t;

	typedef struct packed {
		logic [7:0] acc;
	} msrb_acc_t;

endpackage

// >>> rtl/msrb_accum.sv
// Saturating two's complement displacement accumulator.
// Assumes clear and add come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module msrb_accum (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	// Control
	input  wire logic       i_clear,
	input  wire logic       i_add,
	input  wire logic [7:0] i_delta,
	// Value
	output logic      [7:0] o_value
);
	msrb_pkg::msrb_acc_t st_q;
	msrb_pkg::msrb_acc_t st_d;
	logic [7:0]          base;
	logic [8:0]          sum;

	// Clear first, so a frame in the same cycle is not lost
	always_comb begin
		st_d = st_q;
		base = i_clear ? msrb_pkg::RESET_BYTE : st_q.acc;
		sum  = {base[7], base} + {i_delta[7], i_delta};
		st_d.acc = base;
		if (i_add) begin
			if (sum[8] != sum[7]) begin
				st_d.acc = sum[8] ? msrb_pkg::DISP_NEG_MAX : msrb_pkg::DISP_POS_MAX; // R11
			end else begin
				st_d.acc = sum[7:0];
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_value = st_q.acc;

	chk_sat_positive: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R11
		(i_add && !i_clear && st_q.acc == msrb_pkg::DISP_POS_MAX && !i_delta[7])
		|=> (st_q.acc == msrb_pkg::DISP_POS_MAX))
		else $error("positive displacement wrapped");

endmodule
`default_nettype wire

// >>> rtl/msrb_top.sv
// Register bank of the motion sensor behind its four-wire serial port.
// Assumes serial pins are asynchronous to i_mclk and frame data arrive
// from the imaging core on i_mclk with a one-cycle frame strobe.
`timescale 1ns/100ps
`default_nettype none
module msrb_top #(
	parameter logic [7:0] PART_IDENTITY    = 8'h5C, // Arbitrary value
	parameter logic [7:0] SILICON_REVISION = 8'h3A  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_b,
	// Serial port pins
	input  wire logic                  i_sclk,
	input  wire logic                  i_mosi,
	input  wire logic                  i_ncs_b,
	output logic                       o_miso,
	output logic                       o_miso_oe,
	// Imaging core
	input  wire logic                  i_frame_valid,
	input  wire msrb_pkg::msrb_frame_t i_frame,
	output logic               [15:0]  o_exposure_count
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		msrb_pkg::msrb_pins_t  s1;
		msrb_pkg::msrb_pins_t  s2;
		logic                  sclk_prev;
		msrb_pkg::msrb_phase_t phase;
		logic [2:0]            bit_cnt;
		logic [6:0]            shreg;
		logic                  is_write;
		logic [6:0]            addr;
		logic [7:0]            tx;
		logic                  miso;
		logic                  motion_flag;
		logic [15:0]           exposure;
		logic [7:0]            exposure_low_snap;
		logic [7:0]            surface;
		logic [6:0]            peak;
		logic [7:0]            pix_total;
	} msrb_state_t;

	msrb_state_t st_q;
	msrb_state_t st_d;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        byte_done;
	logic [7:0]  byte_in;
	logic        clr_x;
	logic        clr_y;
	logic [7:0]  x_disp;
	logic [7:0]  y_disp;
	logic [7:0]  surf_raw;
	logic        frame_motion;
	logic [1:0]  clr_axis;
	logic [15:0] delta_axis;
	logic [7:0]  disp_axis [2];

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	function automatic logic [7:0] rd_mux(input logic [6:0] a, input msrb_state_t s,
		input logic [7:0] xd, input logic [7:0] yd);
		logic [7:0] r;
		r = msrb_pkg::RESET_BYTE; // R18
		unique case (a)
			msrb_pkg::ADDR_PART_IDENTITY:    r = PART_IDENTITY; // R03 R04
			msrb_pkg::ADDR_SILICON_REVISION: r = SILICON_REVISION; // R05
			msrb_pkg::ADDR_MOTION_STATUS:    r[msrb_pkg::MOTION_FLAG_BIT] = s.motion_flag; // R06
			msrb_pkg::ADDR_X_DISPLACEMENT:   r = xd; // R09
			msrb_pkg::ADDR_Y_DISPLACEMENT:   r = yd; // R10
			msrb_pkg::ADDR_SURFACE_QUALITY:  r = s.surface;
			msrb_pkg::ADDR_EXPOSURE_HIGH:    r = s.exposure[15:8]; // R15
			msrb_pkg::ADDR_EXPOSURE_LOW:     r = s.exposure_low_snap; // R15
			msrb_pkg::ADDR_PEAK_PIXEL:       r = {1'b0, s.peak};
			msrb_pkg::ADDR_PIXEL_TOTAL:      r = s.pix_total;
			default:                         r = msrb_pkg::RESET_BYTE;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// Serial port and register updates
	// ------------------------------------------------------------
	assign sclk_rise    = st_q.s2.sclk & ~st_q.sclk_prev;
	assign sclk_fall    = ~st_q.s2.sclk & st_q.sclk_prev;
	assign byte_done    = sclk_rise && !st_q.s2.ncs && st_q.bit_cnt == msrb_pkg::LAST_BIT;
	assign byte_in      = {st_q.shreg, st_q.s2.mosi};
	assign frame_motion = i_frame_valid && (i_frame.dx != 8'h00 || i_frame.dy != 8'h00);
	assign surf_raw     = i_frame.features[8:1]; // R13

	always_comb begin
		st_d  = st_q;
		clr_x = 1'b0;
		clr_y = 1'b0;
		st_d.s1        = '{sclk: i_sclk, mosi: i_mosi, ncs: i_ncs_b};
		st_d.s2        = st_q.s1;
		st_d.sclk_prev = st_q.s2.sclk;

		if (st_q.s2.ncs) begin
			// Deselect aborts any transaction
			st_d.phase   = msrb_pkg::MSRB_ADDR;
			st_d.bit_cnt = '0;
		end else begin
			if (sclk_rise) begin
				st_d.shreg   = byte_in[6:0];
				st_d.bit_cnt = st_q.bit_cnt + 3'h1;
			end
			if (sclk_fall && st_q.phase == msrb_pkg::MSRB_DATA && !st_q.is_write) begin
				st_d.miso = st_q.tx[7];
				st_d.tx   = {st_q.tx[6:0], 1'b0};
			end
			if (byte_done) begin
				unique case (st_q.phase)
					msrb_pkg::MSRB_ADDR: begin
						st_d.phase    = msrb_pkg::MSRB_DATA;
						st_d.is_write = byte_in[msrb_pkg::DIR_BIT]; // R02
						st_d.addr     = byte_in[6:0];
						if (!byte_in[msrb_pkg::DIR_BIT]) begin
							st_d.tx = rd_mux(byte_in[6:0], st_q, x_disp, y_disp); // R01 R19
							unique case (byte_in[6:0])
								msrb_pkg::ADDR_MOTION_STATUS:  st_d.motion_flag = 1'b0;
								msrb_pkg::ADDR_X_DISPLACEMENT: clr_x = 1'b1; // R09
								msrb_pkg::ADDR_Y_DISPLACEMENT: clr_y = 1'b1; // R10
								msrb_pkg::ADDR_EXPOSURE_HIGH:
									st_d.exposure_low_snap = st_q.exposure[7:0];
								default: st_d.addr = byte_in[6:0];
							endcase
						end
					end
					msrb_pkg::MSRB_DATA: begin
						st_d.phase = msrb_pkg::MSRB_ADDR;
						// Only motion status reacts; data byte is discarded
						if (st_q.is_write && st_q.addr == msrb_pkg::ADDR_MOTION_STATUS) begin
							st_d.motion_flag = 1'b0; // R07
							clr_x = 1'b1; // R07
							clr_y = 1'b1; // R07
						end
					end
				endcase
			end
		end

		// Frame boundary updates; a new event wins over any clear
		if (i_frame_valid) begin
			st_d.surface   = (surf_raw > msrb_pkg::SURFACE_MAX) ?
				msrb_pkg::SURFACE_MAX : surf_raw; // R13 R14
			st_d.peak      = i_frame.peak; // R19
			st_d.pix_total = i_frame.pix_sum[msrb_pkg::PIX_SUM_HI:msrb_pkg::PIX_SUM_LO];
			if (i_frame.peak > msrb_pkg::PEAK_HIGH_LIMIT &&
				st_q.exposure > msrb_pkg::EXPOSURE_MIN) begin
				st_d.exposure = st_q.exposure - msrb_pkg::EXPOSURE_STEP; // R16
			end else if (i_frame.peak < msrb_pkg::PEAK_LOW_LIMIT &&
				st_q.exposure < msrb_pkg::EXPOSURE_MAX) begin
				st_d.exposure = st_q.exposure + msrb_pkg::EXPOSURE_STEP; // R16
			end
		end
		if (frame_motion) begin
			st_d.motion_flag = 1'b1; // R06
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q                   <= '0;
			st_q.s1                <= msrb_pkg::PINS_RESET;
			st_q.s2                <= msrb_pkg::PINS_RESET;
			st_q.sclk_prev         <= 1'b1;
			st_q.phase             <= msrb_pkg::MSRB_ADDR;
			st_q.exposure          <= msrb_pkg::EXPOSURE_RESET;
			st_q.exposure_low_snap <= msrb_pkg::RESET_BYTE;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Displacement accumulators
	// ------------------------------------------------------------
	// Axis 0 is X, axis 1 is Y
	assign clr_axis   = {clr_y, clr_x};
	assign delta_axis = {i_frame.dy, i_frame.dx};
	assign x_disp     = disp_axis[0];
	assign y_disp     = disp_axis[1];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_axis
			msrb_accum u_accum (
				.i_mclk  (i_mclk),
				.i_rst_b (i_rst_b),
				.i_clear (clr_axis[g]),
				.i_add   (i_frame_valid),
				.i_delta (delta_axis[8*g +: 8]),
				.o_value (disp_axis[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_miso           = st_q.miso;
	assign o_miso_oe        = ~st_q.s2.ncs;
	assign o_exposure_count = st_q.exposure;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_miso_released: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R01
		i_ncs_b [*2] |=> !o_miso_oe)
		else $error("miso driven while deselected");

	chk_identity_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R03
		(byte_done && st_q.phase == msrb_pkg::MSRB_ADDR &&
		byte_in == {1'b0, msrb_pkg::ADDR_PART_IDENTITY}) |=> (st_q.tx == PART_IDENTITY))
		else $error("wrong part identity loaded");

	chk_revision_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R05
		(byte_done && st_q.phase == msrb_pkg::MSRB_ADDR &&
		byte_in == {1'b0, msrb_pkg::ADDR_SILICON_REVISION}) |=> (st_q.tx == SILICON_REVISION))
		else $error("wrong revision loaded");

	chk_flag_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R06
		frame_motion |=> st_q.motion_flag)
		else $error("motion flag missed a frame");

	chk_write_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R07
		(byte_done && st_q.phase == msrb_pkg::MSRB_DATA && st_q.is_write &&
		st_q.addr == msrb_pkg::ADDR_MOTION_STATUS && !i_frame_valid)
		|=> (!st_q.motion_flag && x_disp == 8'h00 && y_disp == 8'h00))
		else $error("motion write did not clear");

	chk_x_read_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R09
		(clr_x && !i_frame_valid) |=> (x_disp == 8'h00))
		else $error("x read did not clear");

	chk_y_read_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R10
		(clr_y && !i_frame_valid) |=> (y_disp == 8'h00))
		else $error("y read did not clear");

	chk_surface_cap: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R13
		st_q.surface <= msrb_pkg::SURFACE_MAX)
		else $error("surface quality above cap");

	chk_surface_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R14
		(i_frame_valid && i_frame.features == 9'h000) |=> (st_q.surface == 8'h00))
		else $error("surface quality not zero");

	chk_exposure_up: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R16
		(i_frame_valid && i_frame.peak < msrb_pkg::PEAK_LOW_LIMIT &&
		st_q.exposure < msrb_pkg::EXPOSURE_MAX)
		|=> (st_q.exposure == $past(st_q.exposure) + msrb_pkg::EXPOSURE_STEP))
		else $error("exposure did not rise");

	chk_tx_stable: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R19
		(st_q.phase == msrb_pkg::MSRB_DATA && !sclk_fall && !st_q.s2.ncs)
		|=> $stable(st_q.tx))
		else $error("read data changed mid byte");

	chk_low_snapshot: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R15
		(byte_done && st_q.phase == msrb_pkg::MSRB_ADDR &&
		byte_in == {1'b0, msrb_pkg::ADDR_EXPOSURE_HIGH})
		|=> (st_q.exposure_low_snap == $past(st_q.exposure[7:0])))
		else $error("exposure low byte not captured");

	chk_write_no_effect: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R18
		(byte_done && st_q.phase == msrb_pkg::MSRB_DATA && st_q.is_write && !i_frame_valid)
		|=> $stable(st_q.exposure))
		else $error("write altered exposure");

endmodule
`default_nettype wire

// >>> verification/msrb_host_model.sv
// Host controller model on the four-wire serial port.
// Assumes the bench clock on i_mclk; sclk half period is four clock cycles.
`timescale 1ns/100ps
`default_nettype none
module msrb_host_model (
	// Clock
	input  wire logic i_mclk,
	// Serial port
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	output logic      o_sclk,
	output logic      o_mosi,
	output logic      o_ncs_b
);
	initial begin
		o_sclk = 1'b1;
		o_mosi = 1'b0;
		o_ncs_b = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// ------------------------------------------------------------
	// One framed access: address byte, then data byte, MSB first
	// ------------------------------------------------------------
	task automatic access(input logic [7:0] a, input logic [7:0] wd,
			output logic [7:0] rd, output logic oe);
		logic [15:0] sh;
		sh = {a, wd};
		rd = 8'h00;
		oe = 1'b1;
		step(1);
		o_ncs_b = 1'b0;
		step(4);
		for (int i = 0; i < 16; i++) begin
			// Gap for the device to fetch read data
			if (i == 8) step(8);
			o_sclk = 1'b0;
			o_mosi = sh[15 - i];
			step(4);
			o_sclk = 1'b1;
			step(2);
			if (i >= 8) begin
				rd = {rd[6:0], i_miso};
				oe = oe & i_miso_oe;
			end
			step(2);
		end
		step(4);
		o_ncs_b = 1'b1;
		// Released line no longer shows the last bit
		o_mosi = ~o_mosi;
		step(8);
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the motion sensor register bank.
// Assumes msrb_pkg compiled first and the host model beside it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [7:0] PART_ID = 8'hA7; // Arbitrary value
	localparam logic [7:0] SIL_REV = 8'h2D; // Arbitrary value

	logic                  i_mclk;
	logic                  i_rst_b;
	logic                  sclk;
	logic                  mosi;
	logic                  ncs_b;
	logic                  miso;
	logic                  miso_oe;
	logic                  i_frame_valid;
	msrb_pkg::msrb_frame_t i_frame;
	logic [15:0]           exposure;
	logic [15:0]           exp_q;
	int                    fail_count;
	int                    compares;

	msrb_top #(.PART_IDENTITY(PART_ID), .SILICON_REVISION(SIL_REV)) uut (
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_mosi(mosi),
		.i_ncs_b(ncs_b), .o_miso(miso), .o_miso_oe(miso_oe),
		.i_frame_valid(i_frame_valid), .i_frame(i_frame),
		.o_exposure_count(exposure));

	msrb_host_model host (.i_mclk(i_mclk), .i_miso(miso), .i_miso_oe(miso_oe),
		.o_sclk(sclk), .o_mosi(mosi), .o_ncs_b(ncs_b));

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       oe;
		host.access({1'b0, a}, 8'h00, d, oe);
		check({8'h00, d}, {8'h00, exp}, "read data");
		check({15'h0000, oe}, 16'h0001, "miso enable in frame");
		check({15'h0000, miso_oe}, 16'h0000, "miso enable idle");
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] wd);
		logic [7:0] d;
		logic       oe;
		host.access({1'b1, a}, wd, d, oe);
	endtask

	task automatic frame(input logic [7:0] dx, input logic [7:0] dy, input logic [8:0] ft,
			input logic [6:0] pk, input logic [14:0] sum);
		@(posedge i_mclk);
		#1;
		i_frame_valid = 1'b1;
		i_frame = '{dx: dx, dy: dy, features: ft, peak: pk, pix_sum: sum};
		if (pk > msrb_pkg::PEAK_HIGH_LIMIT && exp_q > 16'h0001) exp_q = exp_q - 16'h0001;
		else if (pk < msrb_pkg::PEAK_LOW_LIMIT) exp_q = exp_q + 16'h0001;
		@(posedge i_mclk);
		#1;
		i_frame_valid = 1'b0;
		@(posedge i_mclk);
		#1;
		check(exposure, exp_q, "exposure count");
	endtask

	task automatic test_done();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ident();
		check(exposure, 16'h0000, "exposure after reset");
		rd(7'h00, PART_ID);
		rd(7'h01, SIL_REV);
		rd(7'h02, 8'h00);
		rd(7'h03, 8'h00);
		rd(7'h04, 8'h00);
		wr(7'h00, 8'hFF);
		wr(7'h01, 8'hFF);
		rd(7'h00, PART_ID);
		rd(7'h01, SIL_REV);
		rd(7'h0A, 8'h00);
		$display("test ident done");
	endtask

	task automatic t_motion();
		frame(8'h05, 8'hFD, 9'h000, 7'h50, 15'h0000);
		rd(7'h02, 8'h80);
		rd(7'h03, 8'h05);
		rd(7'h04, 8'hFD);
		rd(7'h03, 8'h00);
		rd(7'h04, 8'h00);
		rd(7'h02, 8'h00);
		$display("test motion done");
	endtask

	task automatic t_saturate();
		repeat (3) frame(8'h64, 8'h9C, 9'h000, 7'h50, 15'h0000);
		rd(7'h02, 8'h80);
		rd(7'h03, 8'h7F);
		rd(7'h04, 8'h80);
		frame(8'h01, 8'hFF, 9'h000, 7'h50, 15'h0000);
		wr(7'h02, 8'h5A);
		rd(7'h02, 8'h00);
		rd(7'h03, 8'h00);
		rd(7'h04, 8'h00);
		$display("test saturate done");
	endtask

	task automatic t_measure();
		repeat (3) frame(8'h00, 8'h00, 9'h0A2, 7'h10, 15'h0000);
		rd(7'h05, 8'h51);
		frame(8'h00, 8'h00, 9'h1FF, 7'h7A, 15'h5A80);
		rd(7'h05, 8'h90);
		rd(7'h08, 8'h7A);
		rd(7'h09, 8'hB5);
		rd(7'h06, exp_q[15:8]);
		rd(7'h07, exp_q[7:0]);
		wr(7'h05, 8'h00);
		rd(7'h05, 8'h90);
		frame(8'h00, 8'h00, 9'h000, 7'h50, 15'h0000);
		rd(7'h05, 8'h00);
		$display("test measure done");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		i_rst_b = 1'b0;
		i_frame_valid = 1'b0;
		i_frame = '0;
		exp_q = 16'h0000;
		fail_count = 0;
		compares = 0;
		repeat (8) @(posedge i_mclk);
		#1;
		i_rst_b = 1'b1;
		repeat (4) @(posedge i_mclk);
		#1;
		t_ident();
		t_motion();
		t_saturate();
		t_measure();
		test_done();
	end

	initial begin
		#1_000_000;
		fail_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		test_done();
	end
endmodule
`default_nettype wire
